//--- design/ffp_fuse_protect.sv
/*
 fuse protection logic: fuse word, fetch lock and boot-area protect outputs, page guard,
 fuse commands over a register port, external chip erase.
 assumes the fuse array image is held on fuse_init_i during the load phase after reset and a chip erase
 strobe comes from logic on the same clock; sec_bit_i comes from a pin domain.
*/
// Strobed register access and the register offsets were decided locally.
// Notes on behaviour
// RQ1 - fuse word readable by software at its own register address
// RQ2 - software should leave special-function fuse bits to their purpose
// RQ3 - fuse bits 15:0 are region lock bits, one per region
// RQ4 - fuse bit 16 blocks privileged fetches from external memories
// RQ5 - fetch lock changes only while security bit is clear; else ignored
// RQ6 - with security set, only external chip erase clears the fetch lock
// RQ7 - no external address decode; fetch lock is routed out unchanged
// RQ8 - cpu or bus logic decides which addresses are external
// RQ9 - fetch lock one allows external execution, zero prevents it
// RQ10 - fuse bits 19:17 form the boot-area protect field
// RQ11 - erase or program inside boot area rejected, except chip erase
// RQ12 - boot-area protect field changes only while security bit is clear
// RQ13 - with security set, no internal command alters field or protected pages
// RQ14 - chip erase clears boot-area protect field, making pages programmable
// RQ15 - field 7 protects none; lower values double size, 0 protects 0-127
// RQ16 - single fuse bits change only by fuse write and fuse erase commands
// RQ17 - protection checked at execution; rejection shows as command error
// RQ18 - fuse values loaded after reset before the first fetch is allowed
`timescale 1ns/1ps
module ffp_fuse_protect (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic [ffp_pkg::FUSE_W-1:0] fuse_init_i,
    input wire logic sec_bit_i,
    input wire logic chip_erase_i,
    input wire logic [ffp_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input wire logic pg_req_i,
    input wire logic [ffp_pkg::PAGE_W-1:0] pg_num_i,
    output logic pg_deny_o,
    output logic [ffp_pkg::LOCK_W-1:0] region_lock_o,
    output logic external_fetch_lock_o,
    output logic [ffp_pkg::BAP_W-1:0] boot_area_protect_o,
    output logic fuse_ready_o
);
    import ffp_pkg::*;

    typedef struct packed {
        ffp_state_type state;
        logic [3:0] load_cnt;
        logic [FUSE_W-1:0] fuse;
        logic sec_meta;
        logic sec;
        logic err;
        logic [CMD_W-1:0] cmd;
        logic [4:0] idx;
        logic [31:0] rdata;
        logic pg_deny;
    } ffp_regs_type;

    ffp_regs_type cur_ff;
    ffp_regs_type nxt_ff;

    function automatic logic in_boot_area(input logic [2:0] bap, input logic [PAGE_W-1:0] pg);
        logic [PAGE_W:0] limit;
        limit = '0;
        if (bap != BAP_NONE) begin
            limit = (PAGE_W+1)'(2) << (3'h6 - bap); // RQ15
        end
        in_boot_area = ({1'b0, pg} < limit); // RQ15
    endfunction : in_boot_area

    always_comb begin
        logic [2:0] bap;
        logic protect_hit;
        bap = cur_ff.fuse[BAP_LSB +: BAP_W];
        protect_hit = 1'b0;
        nxt_ff = cur_ff;
        nxt_ff.sec_meta = sec_bit_i;
        nxt_ff.sec = cur_ff.sec_meta;
        nxt_ff.rdata = 32'h00000000;
        nxt_ff.pg_deny = 1'b0;
        case (cur_ff.state)
            FFP_LOAD: begin
                nxt_ff.fuse = fuse_init_i; // RQ18
                if (cur_ff.load_cnt == LOAD_CNT) begin
                    nxt_ff.state = FFP_IDLE; // RQ18
                end else begin
                    nxt_ff.load_cnt = cur_ff.load_cnt + 4'h1;
                end
            end
            FFP_IDLE: begin
                if (reg_wr_i && reg_addr_i == REG_CMD) begin
                    if (reg_wdata_i[CMD_W-1:0] == CMD_FUSE_WRITE ||
                        reg_wdata_i[CMD_W-1:0] == CMD_FUSE_ERASE) begin
                        nxt_ff.cmd = reg_wdata_i[CMD_W-1:0]; // RQ16
                        nxt_ff.idx = reg_wdata_i[12:8];
                        nxt_ff.state = FFP_EXEC;
                        nxt_ff.err = 1'b0;
                    end else begin
                        nxt_ff.err = 1'b1;
                    end
                end
            end
            FFP_EXEC: begin
                if (cur_ff.sec && cur_ff.idx >= 5'(EFL_BIT) &&
                    cur_ff.idx < 5'(BAP_LSB + BAP_W)) begin
                    protect_hit = 1'b1; // RQ5 RQ12 RQ13 RQ17
                end
                if (protect_hit) begin
                    nxt_ff.err = 1'b1; // RQ6 RQ17
                end else if (cur_ff.cmd == CMD_FUSE_WRITE) begin
                    nxt_ff.fuse[cur_ff.idx] = 1'b0; // RQ16
                end else begin
                    nxt_ff.fuse[cur_ff.idx] = 1'b1; // RQ16
                end
                nxt_ff.state = FFP_IDLE;
            end
            default: begin
                nxt_ff.state = FFP_LOAD;
            end
        endcase
        if (cur_ff.state != FFP_LOAD && chip_erase_i) begin
            // a pending command is dropped, so its bit change must not land
            nxt_ff.fuse = cur_ff.fuse;
            nxt_ff.fuse[EFL_BIT] = 1'b1; // RQ6
            nxt_ff.fuse[BAP_LSB +: BAP_W] = BAP_NONE; // RQ14
            nxt_ff.state = FFP_IDLE;
        end
        if (pg_req_i) begin
            nxt_ff.pg_deny = (cur_ff.state == FFP_LOAD) ||
                (!chip_erase_i && in_boot_area(bap, pg_num_i)); // RQ11 RQ13
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                REG_FUSE: nxt_ff.rdata = cur_ff.fuse; // RQ1
                REG_STATUS: begin
                    nxt_ff.rdata[ST_ERR_BIT] = cur_ff.err;
                    nxt_ff.rdata[ST_BUSY_BIT] = (cur_ff.state != FFP_IDLE);
                    nxt_ff.rdata[ST_SEC_BIT] = cur_ff.sec;
                end
                REG_CMD: nxt_ff.rdata = {30'h00000000, cur_ff.cmd};
                default: nxt_ff.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            cur_ff.state <= FFP_LOAD;
            cur_ff.load_cnt <= 4'h0;
            cur_ff.fuse <= FUSE_RESET;
            cur_ff.sec_meta <= 1'b1;
            cur_ff.sec <= 1'b1;
            cur_ff.err <= 1'b0;
            cur_ff.cmd <= 2'h0;
            cur_ff.idx <= 5'h00;
            cur_ff.rdata <= 32'h00000000;
            cur_ff.pg_deny <= 1'b0;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign reg_rdata_o = cur_ff.rdata;
    assign pg_deny_o = cur_ff.pg_deny;
    assign region_lock_o = cur_ff.fuse[LOCK_LSB +: LOCK_W]; // RQ3
    assign external_fetch_lock_o = cur_ff.fuse[EFL_BIT]; // RQ4 RQ7 RQ9
    assign boot_area_protect_o = cur_ff.fuse[BAP_LSB +: BAP_W]; // RQ10
    assign fuse_ready_o = (cur_ff.state != FFP_LOAD); // RQ18
endmodule : ffp_fuse_protect

//--- design/ffp_pkg.sv
/*
 fuse protection package: fuse field layout, register offsets, command codes, timing counts.
 assumes a 32-bit fuse word and 512 flash pages.
*/
package ffp_pkg;
    localparam int unsigned FUSE_W = 32;
    localparam int unsigned LOCK_LSB = 0;
    localparam int unsigned LOCK_W = 16;
    localparam int unsigned EFL_BIT = 16;
    localparam int unsigned BAP_LSB = 17;
    localparam int unsigned BAP_W = 3;
    localparam int unsigned PAGE_W = 9;
    localparam int unsigned CMD_W = 2;
    localparam int unsigned ADDR_W = 8;
    localparam logic [31:0] FUSE_RESET = 32'hffffffff;
    localparam logic [2:0] BAP_NONE = 3'h7;
    localparam logic [7:0] REG_FUSE = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_CMD = 8'h08;
    localparam int unsigned ST_ERR_BIT = 0;
    localparam int unsigned ST_BUSY_BIT = 1;
    localparam int unsigned ST_SEC_BIT = 2;
    localparam logic [1:0] CMD_FUSE_WRITE = 2'h1;
    localparam logic [1:0] CMD_FUSE_ERASE = 2'h2;
    localparam int unsigned CLK_MHZ = 50;
    localparam int unsigned LOAD_NS = 100;
    localparam int unsigned LOAD_CYC = (LOAD_NS * CLK_MHZ + 999) / 1000;
    localparam logic [3:0] LOAD_CNT = 4'(LOAD_CYC);
    typedef enum logic [2:0] {
        FFP_LOAD = 3'b001,
        FFP_IDLE = 3'b010,
        FFP_EXEC = 3'b100
    } ffp_state_type;
endpackage : ffp_pkg

//--- dv/ffp_chk_sva.sv
/* checker: protection assertions on the fuse block ports.
   assumes binding into ffp_fuse_protect. */
`timescale 1ns/1ps
module ffp_chk (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic sec_bit_i,
    input wire logic chip_erase_i,
    input wire logic [ffp_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic pg_req_i,
    input wire logic [ffp_pkg::PAGE_W-1:0] pg_num_i,
    input wire logic pg_deny_o,
    input wire logic [ffp_pkg::LOCK_W-1:0] region_lock_o,
    input wire logic external_fetch_lock_o,
    input wire logic [ffp_pkg::BAP_W-1:0] boot_area_protect_o,
    input wire logic fuse_ready_o
);
    import ffp_pkg::*;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    wire logic hit = boot_area_protect_o != BAP_NONE &&
        32'(pg_num_i) < (32'd2 << (3'd6 - boot_area_protect_o));
    sequence s_load; !fuse_ready_o ##[4:8] fuse_ready_o; endsequence
    sequence s_sec; sec_bit_i [*4] ##0 (fuse_ready_o && !chip_erase_i); endsequence
    rd_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
        else $error("read data not idle");
    fuse_map_a: assert property ($past(reg_rd_i && reg_addr_i == REG_FUSE) |->
        reg_rdata_o[19:0] == $past({boot_area_protect_o, external_fetch_lock_o, region_lock_o}))
        else $error("fuse read mismatch");
    page_deny_a: assert property (pg_req_i && !chip_erase_i |=>
        pg_deny_o == $past(!fuse_ready_o || hit)) else $error("page guard wrong");
    deny_idle_a: assert property (!$past(pg_req_i) |-> !pg_deny_o) else $error("stray deny");
    erase_clear_a: assert property (chip_erase_i |=> external_fetch_lock_o &&
        boot_area_protect_o == BAP_NONE) else $error("chip erase missed");
    sec_hold_a: assert property (s_sec |=> $stable(external_fetch_lock_o) &&
        $stable(boot_area_protect_o)) else $error("protected fuse changed");
    load_ready_a: assert property ($fell(srst_i) |-> s_load) else $error("load late");
    lock_only_cmd_a: assert property (!$past(reg_wr_i) && !$past(reg_wr_i, 2) &&
        !$past(reg_wr_i, 3) && $past(fuse_ready_o, 2) |-> $stable(region_lock_o))
        else $error("lock changed without command");
endmodule : ffp_chk
bind ffp_fuse_protect ffp_chk chk (.*);

//--- dv/ffp_cpu_model.sv
/* cpu side model: grants external fetch from the routed fetch lock.
   assumes the same clock as the fuse block. */
`timescale 1ns/1ps
module ffp_cpu_model (
    input wire logic ref_clk_i,
    input wire logic fuse_ready_i,
    input wire logic fetch_lock_i,
    output logic ext_fetch_ok_o
);
    always_ff @(posedge ref_clk_i) begin
        ext_fetch_ok_o <= fuse_ready_i && fetch_lock_i;
    end
endmodule : ffp_cpu_model

//--- dv/ffp_tb.sv
/* testbench: fuse reads, fuse commands, page guard, security and chip erase.
   assumes the fuse block, its checker and the cpu model. */
`timescale 1ns/1ps
module tb;
    import ffp_pkg::*;
    logic ref_clk_i = 0, srst_i = 1, sec_bit_i = 0, chip_erase_i = 0, ok;
    logic reg_wr_i = 0, reg_rd_i = 0, pg_req_i = 0, pg_deny_o, external_fetch_lock_o, fuse_ready_o;
    logic [7:0] reg_addr_i = 0;
    logic [8:0] pg_num_i = 0;
    logic [31:0] reg_wdata_i = 0, reg_rdata_o, fuse_init_i = 32'hfffd5a5a;
    logic [15:0] region_lock_o;
    logic [2:0] boot_area_protect_o;
    int n_errors = 0, checks_done = 0;
    always #10 ref_clk_i = ~ref_clk_i;
    ffp_fuse_protect uut (.*);
    ffp_cpu_model cpu (.ref_clk_i, .fuse_ready_i(fuse_ready_o),
        .fetch_lock_i(external_fetch_lock_o), .ext_fetch_ok_o(ok));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        reg_wr_i <= 1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge ref_clk_i);
        reg_wr_i <= 0;
        repeat (3) @(posedge ref_clk_i);
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge ref_clk_i);
        reg_rd_i <= 1;
        reg_addr_i <= a;
        @(posedge ref_clk_i);
        reg_rd_i <= 0;
        #1 chk(reg_rdata_o & m, e);
    endtask : rd
    task pg(input logic [8:0] n, input logic e);
        @(posedge ref_clk_i);
        pg_req_i <= 1;
        pg_num_i <= n;
        @(posedge ref_clk_i);
        pg_req_i <= 0;
        #1 chk(32'(pg_deny_o), 32'(e));
    endtask : pg
    task final_report;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    initial begin
        repeat (8) @(posedge ref_clk_i);
        srst_i <= 0;
        for (int i = 0; i < 20 && fuse_ready_o !== 1'b1; i++) @(posedge ref_clk_i);
        if (fuse_ready_o !== 1'b1) n_errors++;
        else begin
        rd(REG_FUSE, 32'hfffff, 32'hd5a5a);
        chk(32'(region_lock_o), 32'h5a5a);
        chk(32'(boot_area_protect_o), 32'h6);
        rd(8'h0c, '1, 32'h0);
        wr(8'h0c, 32'h1001);
        pg(9'h1, 1);
        pg(9'h2, 0);
        wr(REG_CMD, 32'h1301);
        pg(9'h1f, 1);
        pg(9'h20, 0);
        rd(REG_STATUS, 32'h7, 32'h0);
        wr(REG_CMD, 32'h3);
        rd(REG_STATUS, 32'h7, 32'h1);
        rd(REG_CMD, '1, 32'h1);
        wr(REG_CMD, 32'h1001);
        chk(32'(external_fetch_lock_o), 32'h0);
        rd(REG_STATUS, 32'h7, 32'h0);
        rd(REG_FUSE, 32'hfffff, 32'h45a5a);
        chk(32'(ok), 32'h0);
        $display("commands done");
        @(posedge ref_clk_i) sec_bit_i <= 1;
        repeat (4) @(posedge ref_clk_i);
        wr(REG_CMD, 32'h1002);
        wr(REG_CMD, 32'h1302);
        rd(REG_FUSE, 32'hfffff, 32'h45a5a);
        rd(REG_STATUS, 32'h7, 32'h5);
        @(posedge ref_clk_i) chip_erase_i <= 1;
        @(posedge ref_clk_i) chip_erase_i <= 0;
        rd(REG_FUSE, 32'hfffff, 32'hf5a5a);
        pg(9'h0, 0);
        chk(32'(ok), 32'h1);
        chk(32'(boot_area_protect_o), 32'h7);
        $display("security done");
        @(posedge ref_clk_i) srst_i <= 1;
        repeat (2) @(posedge ref_clk_i);
        #1 chk(32'(fuse_ready_o), 32'h0);
        @(posedge ref_clk_i) srst_i <= 0;
        for (int i = 0; i < 20 && fuse_ready_o !== 1'b1; i++) @(posedge ref_clk_i);
        chk(32'(fuse_ready_o), 32'h1);
        rd(REG_FUSE, 32'hfffff, 32'hd5a5a);
        $display("reset done");
        end
        final_report;
    end
endmodule : tb
